/* File: hdl/tcc_timer_unit.sv */
// Eight-channel capture/compare timer with an AXI4-Lite register port.
// Assumes channel pins are synchronous to sys_clk; reset is synchronous.
//
// Notes on behaviour
// - Eight channels share one 16-bit up-counter.
// - Coarse prescaler divides by powers of two.
// - Precision prescaler divides by 1 to 256.
// - Precision divisor is register value plus one.
// - Select bit picks exactly one prescaler.
// - Counter advances only while timer enabled.
// - Mode bit: clear capture, set compare.
// - Active pin edge copies counter into channel.
// - Edge select: off, rise, fall, both.
// - Capture sets flag; enable gates interrupt.
// - Write one clears flag, only while enabled.
// - Compare match acts on pin, sets flag.
// - Action: none, toggle, low, high.
// - Compare flag interrupts only when enabled.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_unit #(
	parameter int NCH   = tcc_pkg::NCH,
	parameter int CNT_W = tcc_pkg::CNT_W
) (
	input  wire logic                   sys_clk,
	input  wire logic                   srst,
	input  wire tcc_pkg::tcc_axil_req_t axi_req,
	output tcc_pkg::tcc_axil_rsp_t      axi_rsp,
	input  wire logic [NCH-1:0]         chan_pin_in,
	output logic [NCH-1:0]              chan_pin_out,
	output logic [NCH-1:0]              chan_pin_oe,
	output logic                        irq
);

	// ==================================================================
	// Registers
	logic [1:0]       ctrl_one_r;
	logic [2:0]       ctrl_two_r;
	logic [7:0]       prec_r;
	logic [NCH-1:0]   mode_r;
	logic [2*NCH-1:0] edge_r;
	logic [2*NCH-1:0] action_r;
	logic [NCH-1:0]   flags_r;
	logic [NCH-1:0]   ie_r;
	logic [CNT_W-1:0] counter_r;
	logic [CNT_W-1:0] chan_val_r [NCH];
	logic [NCH-1:0]   pin_prev_r;
	logic [NCH-1:0]   pin_out_r;
	logic             irq_r;

	// ==================================================================
	// Write channel state
	logic             aw_hold_r;
	logic [7:0]       aw_addr_r;
	logic             w_hold_r;
	logic [31:0]      w_data_r;
	logic [3:0]       w_strb_r;
	logic             bvalid_r;
	logic [1:0]       bresp_r;

	// ==================================================================
	// Read channel state
	logic             rvalid_r;
	logic [31:0]      rdata_r;
	logic [1:0]       rresp_r;

	// ==================================================================
	// Handshake wires
	logic             awready;
	logic             wready;
	logic             arready;
	logic             aw_take;
	logic             w_take;
	logic             ar_take;
	logic             do_write;

	assign awready  = !aw_hold_r && !bvalid_r;
	assign wready   = !w_hold_r && !bvalid_r;
	assign arready  = !rvalid_r;
	assign aw_take  = axi_req.awvalid && awready;
	assign w_take   = axi_req.wvalid && wready;
	assign ar_take  = axi_req.arvalid && arready;
	assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

	assign axi_rsp.awready = awready;
	assign axi_rsp.wready  = wready;
	assign axi_rsp.bvalid  = bvalid_r;
	assign axi_rsp.bresp   = bresp_r;
	assign axi_rsp.arready = arready;
	assign axi_rsp.rvalid  = rvalid_r;
	assign axi_rsp.rdata   = rdata_r;
	assign axi_rsp.rresp   = rresp_r;

	// ==================================================================
	// Write decode
	logic [31:0]      wmask;
	logic [31:0]      wbits;
	logic [31:0]      wkeep;
	logic             w_aligned;
	logic             w_chan;
	logic [2:0]       w_idx;
	logic             wr_ctrl_one;
	logic             wr_ctrl_two;
	logic             wr_prec;
	logic             wr_mode;
	logic             wr_edge;
	logic             wr_action;
	logic             wr_flags;
	logic             wr_ie;
	logic             wr_count;
	logic             w_mapped;

	assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
		{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	assign wbits = w_data_r & wmask;
	assign wkeep = ~wmask;
	assign w_aligned = aw_addr_r[1:0] == 2'h0;
	assign w_chan = w_aligned && aw_addr_r[7:5] == tcc_pkg::OFF_CHAN_HI;
	assign w_idx  = aw_addr_r[4:2];
	assign wr_ctrl_one = do_write && aw_addr_r == tcc_pkg::OFF_CTRL_ONE;
	assign wr_ctrl_two = do_write && aw_addr_r == tcc_pkg::OFF_CTRL_TWO;
	assign wr_prec   = do_write && aw_addr_r == tcc_pkg::OFF_PREC;
	assign wr_mode   = do_write && aw_addr_r == tcc_pkg::OFF_MODE;
	assign wr_edge   = do_write && aw_addr_r == tcc_pkg::OFF_EDGE;
	assign wr_action = do_write && aw_addr_r == tcc_pkg::OFF_ACTION;
	assign wr_flags  = do_write && aw_addr_r == tcc_pkg::OFF_FLAGS;
	assign wr_ie     = do_write && aw_addr_r == tcc_pkg::OFF_IE;
	assign wr_count  = aw_addr_r == tcc_pkg::OFF_COUNT;
	assign w_mapped  = wr_ctrl_one || wr_ctrl_two || wr_prec || wr_mode
		|| wr_edge || wr_action || wr_flags || wr_ie
		|| (do_write && (w_chan || wr_count));

	// ==================================================================
	// Timer control wires
	logic             timer_enable_bit;
	logic             precision_select;
	logic             tick;
	logic [CNT_W-1:0] cnt_next;
	logic [NCH-1:0]   flag_clr;
	logic [NCH-1:0]   flag_set;

	assign timer_enable_bit = ctrl_one_r[tcc_pkg::EN_BIT];
	assign precision_select = ctrl_one_r[tcc_pkg::PSEL_BIT];
	assign cnt_next = counter_r + CNT_W'(1);
	// Clearing with the timer stopped has no effect.
	assign flag_clr = (wr_flags && timer_enable_bit) ?
		wbits[NCH-1:0] : '0;

	// ==================================================================
	// Bus write transactions
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_hold_r  <= 1'b0;
			w_data_r  <= 32'h0000_0000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= tcc_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= axi_req.awaddr;
			end
			if (w_take) begin
				w_hold_r <= 1'b1;
				w_data_r <= axi_req.wdata;
				w_strb_r <= axi_req.wstrb;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= w_mapped ? tcc_pkg::RESP_OKAY
					: tcc_pkg::RESP_SLVERR;
			end else if (bvalid_r && axi_req.bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// ==================================================================
	// Software registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_one_r <= tcc_pkg::RST_CTRL_ONE;
			ctrl_two_r <= tcc_pkg::RST_CTRL_TWO;
			prec_r     <= tcc_pkg::RST_PREC;
			mode_r     <= tcc_pkg::RST_BYTE;
			edge_r     <= tcc_pkg::RST_PAIRS;
			action_r   <= tcc_pkg::RST_PAIRS;
			ie_r       <= tcc_pkg::RST_BYTE;
		end else begin
			if (wr_ctrl_one)
				ctrl_one_r <= (ctrl_one_r & wkeep[1:0]) | wbits[1:0];
			if (wr_ctrl_two)
				ctrl_two_r <= (ctrl_two_r & wkeep[2:0]) | wbits[2:0];
			if (wr_prec)
				prec_r <= (prec_r & wkeep[7:0]) | wbits[7:0];
			if (wr_mode)
				mode_r <= (mode_r & wkeep[7:0]) | wbits[7:0];
			if (wr_edge)
				edge_r <= (edge_r & wkeep[15:0]) | wbits[15:0];
			if (wr_action)
				action_r <= (action_r & wkeep[15:0]) | wbits[15:0];
			if (wr_ie)
				ie_r <= (ie_r & wkeep[7:0]) | wbits[7:0];
		end
	end

	// ==================================================================
	// Prescalers and shared counter
	tcc_prescaler #(
		.CW (7),
		.FW (8)
	) u_prescaler (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.run        (timer_enable_bit),
		.use_fine   (precision_select),
		.coarse_sel (ctrl_two_r),
		.fine_val   (prec_r),
		.tick       (tick)
	);

	// Software may preset the counter; a tick in the same cycle loses.
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			counter_r <= tcc_pkg::RST_VALUE;
		end else if (do_write && wr_count) begin
			counter_r <= (counter_r & wkeep[15:0]) | wbits[15:0];
		end else if (tick) begin
			counter_r <= cnt_next;
		end
	end

	// ==================================================================
	// Channels
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chan
			logic       rise;
			logic       fall;
			logic [1:0] edge_cfg;
			logic [1:0] act_cfg;
			logic       cap_hit;
			logic       cmp_hit;
			logic       wr_val;

			assign edge_cfg = edge_r[2*gi+1:2*gi];
			assign act_cfg  = action_r[2*gi+1:2*gi];
			assign rise = chan_pin_in[gi] && !pin_prev_r[gi];
			assign fall = !chan_pin_in[gi] && pin_prev_r[gi];
			assign cap_hit = !mode_r[gi] && ((edge_cfg[0] && rise)
				|| (edge_cfg[1] && fall));
			// Matching the value being entered fires once per pass.
			assign cmp_hit = mode_r[gi] && tick
				&& cnt_next == chan_val_r[gi];
			assign wr_val = do_write && w_chan && w_idx == 3'(gi);
			assign flag_set[gi] = cap_hit || cmp_hit;

			always_ff @(posedge sys_clk) begin
				if (srst) begin
					pin_prev_r[gi] <= 1'b0;
				end else begin
					pin_prev_r[gi] <= chan_pin_in[gi];
				end
			end

			// A capture beats a bus write in the same cycle.
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					chan_val_r[gi] <= tcc_pkg::RST_VALUE;
				end else if (cap_hit) begin
					chan_val_r[gi] <= counter_r;
				end else if (wr_val) begin
					chan_val_r[gi] <= (chan_val_r[gi] & wkeep[15:0])
						| wbits[15:0];
				end
			end

			always_ff @(posedge sys_clk) begin
				if (srst) begin
					pin_out_r[gi] <= 1'b0;
				end else if (cmp_hit) begin
					case (act_cfg)
						tcc_pkg::ACT_TOGGLE: pin_out_r[gi] <= !pin_out_r[gi];
						tcc_pkg::ACT_LOW:    pin_out_r[gi] <= 1'b0;
						tcc_pkg::ACT_HIGH:   pin_out_r[gi] <= 1'b1;
						default:             pin_out_r[gi] <= pin_out_r[gi];
					endcase
				end
			end
		end
	endgenerate

	assign chan_pin_out = pin_out_r;
	assign chan_pin_oe  = mode_r;

	// ==================================================================
	// Event flags and interrupt
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			flags_r <= tcc_pkg::RST_BYTE;
			irq_r   <= 1'b0;
		end else begin
			// A new event wins over a clear in the same cycle.
			flags_r <= flag_set | (flags_r & ~flag_clr);
			irq_r   <= |(flags_r & ie_r);
		end
	end

	assign irq = irq_r;

	// ==================================================================
	// Read path
	logic [31:0] rd_word;
	logic        rd_ok;
	logic [7:0]  ra;

	assign ra = axi_req.araddr;

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = 1'b1;
		if (ra[1:0] != 2'h0) begin
			rd_ok = 1'b0;
		end else if (ra[7:5] == tcc_pkg::OFF_CHAN_HI) begin
			rd_word[CNT_W-1:0] = chan_val_r[ra[4:2]];
		end else begin
			case (ra)
				tcc_pkg::OFF_CTRL_ONE: rd_word[1:0]       = ctrl_one_r;
				tcc_pkg::OFF_CTRL_TWO: rd_word[2:0]       = ctrl_two_r;
				tcc_pkg::OFF_PREC:     rd_word[7:0]       = prec_r;
				tcc_pkg::OFF_MODE:     rd_word[NCH-1:0]   = mode_r;
				tcc_pkg::OFF_EDGE:     rd_word[2*NCH-1:0] = edge_r;
				tcc_pkg::OFF_ACTION:   rd_word[2*NCH-1:0] = action_r;
				tcc_pkg::OFF_FLAGS:    rd_word[NCH-1:0]   = flags_r;
				tcc_pkg::OFF_IE:       rd_word[NCH-1:0]   = ie_r;
				tcc_pkg::OFF_COUNT:    rd_word[CNT_W-1:0] = counter_r;
				default:               rd_ok              = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= tcc_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_ok ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
		end else if (rvalid_r && axi_req.rready) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* File: hdl/tcc_pkg.sv */
// Package of the timer capture/compare unit: map, fields, bus structs.
// Assumes one 50 MHz clock and an AXI4-Lite master with 32-bit data.
`default_nettype none
package tcc_pkg;

	// ==================================================================
	// Sizes
	localparam int NCH   = 8;
	localparam int CNT_W = 16;
	localparam int ADR_W = 8;

	// ==================================================================
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL_ONE = 8'h00;
	localparam logic [7:0] OFF_CTRL_TWO = 8'h04;
	localparam logic [7:0] OFF_PREC     = 8'h08;
	localparam logic [7:0] OFF_MODE     = 8'h0C;
	localparam logic [7:0] OFF_EDGE     = 8'h10;
	localparam logic [7:0] OFF_ACTION   = 8'h14;
	localparam logic [7:0] OFF_FLAGS    = 8'h18;
	localparam logic [7:0] OFF_IE       = 8'h1C;
	localparam logic [7:0] OFF_COUNT    = 8'h20;
	localparam logic [2:0] OFF_CHAN_HI  = 3'h2;

	// ==================================================================
	// Field positions and reset values
	localparam int EN_BIT   = 0;
	localparam int PSEL_BIT = 1;
	localparam logic [1:0]  RST_CTRL_ONE = 2'h0;
	localparam logic [2:0]  RST_CTRL_TWO = 3'h0;
	localparam logic [7:0]  RST_PREC     = 8'h00;
	localparam logic [7:0]  RST_BYTE     = 8'h00;
	localparam logic [15:0] RST_PAIRS    = 16'h0000;
	localparam logic [15:0] RST_VALUE    = 16'h0000;

	// ==================================================================
	// Action and response codes
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_LOW    = 2'h2;
	localparam logic [1:0] ACT_HIGH   = 2'h3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================================
	// Bus carriers
	typedef struct packed {
		logic             awvalid;
		logic [ADR_W-1:0] awaddr;
		logic             wvalid;
		logic [31:0]      wdata;
		logic [3:0]       wstrb;
		logic             bready;
		logic             arvalid;
		logic [ADR_W-1:0] araddr;
		logic             rready;
	} tcc_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} tcc_axil_rsp_t;

endpackage
`default_nettype wire

/* File: hdl/tcc_prescaler.sv */
// Two selectable prescalers making the counter tick.
// Assumes its settings are stable registers of the parent.
`timescale 1ns/100ps
`default_nettype none
module tcc_prescaler #(
	parameter int CW = 7,
	parameter int FW = 8
) (
	input  wire logic          sys_clk,
	input  wire logic          srst,
	input  wire logic          run,
	input  wire logic          use_fine,
	input  wire logic [2:0]    coarse_sel,
	input  wire logic [FW-1:0] fine_val,
	output logic               tick
);

	// ==================================================================
	// Coarse divider
	logic [CW-1:0] coarse_r;
	logic [CW-1:0] coarse_mask;
	logic          coarse_tick;
	logic [FW-1:0] fine_r;
	logic          fine_tick;

	assign coarse_mask = CW'((1 << coarse_sel) - 1);
	assign coarse_tick = (coarse_r & coarse_mask) == coarse_mask;
	assign fine_tick   = fine_r == fine_val;
	assign tick = run & (use_fine ? fine_tick : coarse_tick);

	always_ff @(posedge sys_clk) begin
		if (srst || !run) begin
			coarse_r <= '0;
		end else begin
			coarse_r <= coarse_r + CW'(1);
		end
	end

	// ==================================================================
	// Fine divider; value plus one cycles per tick.
	always_ff @(posedge sys_clk) begin
		if (srst || !run || fine_tick) begin
			fine_r <= '0;
		end else begin
			fine_r <= fine_r + FW'(1);
		end
	end

endmodule
`default_nettype wire

/* File: test/tcc_pin_model.sv */
// Outside world at the channel pins: a source for capture inputs.
// Assumes the bench sets the wanted levels just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_model (
	input  wire logic [7:0] drive_lvl,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output logic [7:0]      pin_in
);
	// A driven pin reads back the unit's level; a free pin follows the
	// outside source, so the unit never sees a stale value of its own.
	assign pin_in = (pin_out & pin_oe) | (drive_lvl & ~pin_oe);
endmodule
`default_nettype wire

/* File: test/tcc_timer_properties.sv */
// Checker of the timer unit, seeing only its top-level ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_properties #(
	parameter int NCH   = 8,
	parameter int CNT_W = 16
) (
	input wire logic                   sys_clk,
	input wire logic                   srst,
	input wire tcc_pkg::tcc_axil_req_t axi_req,
	input wire tcc_pkg::tcc_axil_rsp_t axi_rsp,
	input wire logic [NCH-1:0]         chan_pin_in,
	input wire logic [NCH-1:0]         chan_pin_out,
	input wire logic [NCH-1:0]         chan_pin_oe,
	input wire logic                   irq
);
	// ==================================================================
	// Bus and pin relations
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	// Address and data are parked for one cycle before the response.
	wr_answer_a: assert property (axi_req.awvalid && axi_rsp.awready &&
		axi_req.wvalid && axi_rsp.wready |=> ##1 axi_rsp.bvalid)
		else $error("write response late");
	b_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
		|=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
		else $error("write response dropped");
	rd_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
		|=> axi_rsp.rvalid)
		else $error("read response late");
	r_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
		|=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
		else $error("read data dropped");
	ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
		else $error("read address taken while busy");
	aw_block_a: assert property (axi_rsp.bvalid
		|-> !axi_rsp.awready && !axi_rsp.wready)
		else $error("write taken while busy");
	capture_quiet_a: assert property (
		((chan_pin_out ^ $past(chan_pin_out)) & ~chan_pin_oe &
		~$past(chan_pin_oe)) == '0)
		else $error("capture pin output moved");
	mode_write_a: assert property (
		!$stable(chan_pin_oe) |-> axi_rsp.bvalid || $past(axi_rsp.bvalid))
		else $error("pin mode changed without a write");
	reset_idle_a: assert property ($past(srst) |-> !irq &&
		chan_pin_oe == '0 && !axi_rsp.bvalid && !axi_rsp.rvalid)
		else $error("outputs not idle after reset");
endmodule

bind tcc_timer_unit tcc_timer_properties #(
	.NCH   (NCH),
	.CNT_W (CNT_W)
) u_tcc_timer_properties (
	.sys_clk      (sys_clk),
	.srst         (srst),
	.axi_req      (axi_req),
	.axi_rsp      (axi_rsp),
	.chan_pin_in  (chan_pin_in),
	.chan_pin_out (chan_pin_out),
	.chan_pin_oe  (chan_pin_oe),
	.irq          (irq)
);
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench of the timer unit over its register bus.
// Assumes the package and the pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic                   sys_clk;
	logic                   srst;
	tcc_pkg::tcc_axil_req_t q;
	tcc_pkg::tcc_axil_rsp_t s;
	logic [7:0]             lvl;
	logic [7:0]             pin_in;
	logic [7:0]             pout;
	logic [7:0]             poe;
	logic                   irq;
	logic [31:0]            rv;
	logic [31:0]            r;
	logic [1:0]             resp;
	int                     n_mismatch;
	int                     checked;
	int                     seed;
	int                     i;

	tcc_timer_unit u_tcc_timer_unit (
		.sys_clk      (sys_clk),
		.srst         (srst),
		.axi_req      (q),
		.axi_rsp      (s),
		.chan_pin_in  (pin_in),
		.chan_pin_out (pout),
		.chan_pin_oe  (poe),
		.irq          (irq)
	);
	tcc_pin_model u_tcc_pin_model (
		.drive_lvl (lvl),
		.pin_out   (pout),
		.pin_oe    (poe),
		.pin_in    (pin_in)
	);

	always #10 sys_clk = ~sys_clk;

	// ==================================================================
	// Tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic bound(input int n);
		if (n >= 20) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		q.awvalid <= 1'b1;
		q.awaddr  <= a;
		q.wvalid  <= 1'b1;
		q.wdata   <= d;
		q.bready  <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (s.awready) q.awvalid <= 1'b0;
			if (s.wready) q.wvalid <= 1'b0;
			if (s.bvalid) break;
		end
		resp = s.bresp;
		q.bready <= 1'b0;
		bound(n);
	endtask

	task automatic rd(input logic [7:0] a);
		int n;
		@(posedge sys_clk);
		q.arvalid <= 1'b1;
		q.araddr  <= a;
		q.rready  <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge sys_clk);
			if (s.arready) q.arvalid <= 1'b0;
			if (s.rvalid) break;
		end
		rv = s.rdata;
		resp = s.rresp;
		q.rready <= 1'b0;
		bound(n);
	endtask

	function automatic int divisor(input logic [1:0] c1,
		input logic [2:0] cs, input logic [7:0] pv);
		return c1[1] ? int'(pv) + 1 : 1 << cs;
	endfunction

	// Channel 0 catches the rise, channel 1 the fall, k*d cycles apart;
	// the count starts at its top so the window usually spans the wrap.
	task automatic meas(input logic [1:0] c1, input logic [2:0] cs,
		input logic [7:0] pv);
		int          d;
		int          k;
		logic [15:0] v0;
		logic [31:0] e;
		d = divisor(c1, cs, pv);
		k = 1 + ({$random(seed)} % 3);
		e = c1[0] ? k : 0;
		wr(tcc_pkg::OFF_CTRL_ONE, 32'h0);
		wr(tcc_pkg::OFF_CTRL_TWO, {29'h0, cs});
		wr(tcc_pkg::OFF_PREC, {24'h0, pv});
		wr(tcc_pkg::OFF_COUNT, 32'h0000FFFF);
		wr(tcc_pkg::OFF_CTRL_ONE, {30'h0, c1});
		@(posedge sys_clk);
		lvl[1:0] <= 2'h3;
		repeat (k * d) @(posedge sys_clk);
		lvl[1:0] <= 2'h0;
		rd(8'h40);
		v0 = rv[15:0];
		rd(8'h44);
		chk("ticks", {16'h0, rv[15:0] - v0}, e);
	endtask

	task automatic cmp(input logic [31:0] act, input logic [3:0] e);
		wr(tcc_pkg::OFF_ACTION, act);
		wr(tcc_pkg::OFF_CTRL_ONE, 32'h0);
		wr(tcc_pkg::OFF_COUNT, 32'h0);
		wr(tcc_pkg::OFF_CTRL_ONE, 32'h1);
		repeat (40) @(posedge sys_clk);
		chk("pins", {28'h0, pout[5:2]}, {28'h0, e});
	endtask

	// ==================================================================
	// Main sequence
	initial begin
		seed = 32'h072d32f6;
		sys_clk = 1'b0;
		srst = 1'b1;
		q = '0;
		q.wstrb = 4'hF;
		lvl = 8'h00;
		n_mismatch = 0;
		checked = 0;
		repeat (20) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		for (i = 0; i < 9; i++) begin
			rd(8'(4 * i));
			chk("reset", rv, 32'h0);
		end
		rd(8'h24);
		chk("rresp", {30'h0, resp}, {30'h0, tcc_pkg::RESP_SLVERR});
		wr(8'h24, 32'h1);
		chk("bresp", {30'h0, resp}, {30'h0, tcc_pkg::RESP_SLVERR});
		wr(tcc_pkg::OFF_EDGE, 32'h9);
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			meas(2'h1, i[2:0], r[7:0]);
		end
		meas(2'h3, r[2:0], 8'h18);
		meas(2'h3, r[5:3], 8'hFF);
		for (i = 0; i < 3; i++) begin
			r = $random(seed);
			meas(2'h3, r[2:0], r[15:8]);
		end
		meas(2'h0, 3'h0, 8'h00);
		rd(tcc_pkg::OFF_FLAGS);
		chk("flags", rv, 32'h3);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(tcc_pkg::OFF_IE, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk("irq", {31'h0, irq}, 32'h1);
		wr(tcc_pkg::OFF_FLAGS, 32'h3);
		rd(tcc_pkg::OFF_FLAGS);
		chk("flags", rv, 32'h3);
		wr(tcc_pkg::OFF_CTRL_ONE, 32'h1);
		wr(tcc_pkg::OFF_FLAGS, 32'h1);
		rd(tcc_pkg::OFF_FLAGS);
		chk("flags", rv, 32'h2);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(tcc_pkg::OFF_MODE, 32'h3C);
		for (i = 2; i < 6; i++) wr(8'h40 + 8'(4 * i), 32'h10);
		cmp(32'hFF0, 4'hF);
		cmp(32'hE40, 4'h9);
		chk("oe", {24'h0, poe}, 32'h3C);
		rd(tcc_pkg::OFF_FLAGS);
		chk("flags", rv, 32'h3E);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(tcc_pkg::OFF_IE, 32'h4);
		repeat (2) @(posedge sys_clk);
		chk("irq", {31'h0, irq}, 32'h1);
		give_verdict();
	end
endmodule
`default_nettype wire
